// File: hw/snpm_core.sv
`timescale 1ns/1ps
module snpm_core (
    input  wire logic                         clk,           // system clock, 40 MHz
    input  wire logic                         sys_rst,       // sync reset, high
    input  wire logic                         spi_cs_n,      // chip select pin, low active
    input  wire logic                         spi_sck,       // serial clock pin
    input  wire logic                         spi_si,        // serial data in pin
    output logic                              spi_so,        // serial data out
    output logic                              spi_so_oe_n,   // so enable, low drives
    input  wire logic [snpm_pkg::SN_W-1:0]    sn_value,      // stored serial number
    input  wire logic                         acc_valid,     // array byte access
    input  wire logic                         acc_first,     // first byte of burst
    input  wire logic [snpm_pkg::ADDR_W-1:0]  acc_addr,      // array byte address
    output logic                              row_act,       // row opened pulse
    output logic      [snpm_pkg::ROW_W-1:0]   row_idx,       // opened row
    output logic                              pw_deep_sleep, // in deep sleep
    output logic                              pw_hibernate,  // in hibernate
    output logic                              pw_waking      // exit interval running
);
    import snpm_pkg::*;

    logic [PIN_W-1:0] pin_lvl;
    logic [PIN_W-1:0] pin_rise;
    logic [PIN_W-1:0] pin_fall;

    snpm_sync u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .pin_in   ({spi_si, spi_sck, spi_cs_n}),
        .pin_lvl  (pin_lvl),
        .pin_rise (pin_rise),
        .pin_fall (pin_fall)
    );

    snpm_row_track u_row (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .acc_valid (acc_valid),
        .acc_first (acc_first),
        .acc_addr  (acc_addr),
        .row_act   (row_act),
        .row_idx   (row_idx)
    );

    function automatic logic [7:0] sn_byte(input logic [SN_W-1:0] sn, input logic [2:0] idx);
        sn_byte = sn[idx*8 +: 8];
    endfunction : sn_byte

    snpm_pw_e         pw;
    snpm_xf_e         xf;
    snpm_pend_e       pend;
    logic [TMR_W-1:0] tmr;
    logic [6:0]       op_sh;
    logic [2:0]       bit_cnt;
    logic [7:0]       tx_sh;
    logic [2:0]       tx_cnt;
    logic [2:0]       byte_idx;
    logic             so_drive;

    wire       cs_low   = !pin_lvl[PIN_CS];
    wire       cs_fall  = pin_fall[PIN_CS];
    wire       cs_rise  = pin_rise[PIN_CS];
    wire       sck_rise = pin_rise[PIN_SCK];
    wire       sck_fall = pin_fall[PIN_SCK];
    wire       si       = pin_lvl[PIN_SI];
    wire       active   = (pw == PW_ACTIVE);
    wire [7:0] op_full  = {op_sh, si};
    wire       op_done  = active && xf == XF_OPCODE && sck_rise && bit_cnt == BIT_LAST;
    wire       sn_start = op_done && op_full == READ_SERIAL_CMD;
    wire       sn_shift = active && xf == XF_SERIAL && sck_fall;
    wire       sn_next  = sn_shift && tx_cnt == BIT_LAST;
    wire [11:0] tmr_inc = tmr + TMR_ONE;

    // frame decoder: runs only while the power state is normal
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            xf       <= XF_IGNORE;
            pend     <= PD_NONE;
            op_sh    <= '0;
            bit_cnt  <= '0;
            tx_sh    <= '0;
            tx_cnt   <= '0;
            byte_idx <= SN_FIRST;
            so_drive <= 1'b0;
            spi_so   <= 1'b0;
        end else if (!active || cs_rise) begin
            xf       <= XF_IGNORE;
            so_drive <= 1'b0;
            if (!active || cs_rise) begin
                pend <= PD_NONE;
            end
        end else if (cs_fall) begin
            xf      <= XF_OPCODE;
            bit_cnt <= '0;
            op_sh   <= '0;
        end else if (xf == XF_OPCODE && sck_rise) begin
            op_sh   <= op_full[6:0];
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST) begin
                xf <= XF_IGNORE;
                if (op_full == READ_SERIAL_CMD) begin
                    xf       <= XF_SERIAL;
                    tx_sh    <= sn_byte(sn_value, SN_FIRST);
                    tx_cnt   <= '0;
                    byte_idx <= SN_FIRST + 3'h1;
                end else if (op_full == DEEP_SLEEP_CMD) begin
                    pend <= PD_DEEP;
                end else if (op_full == HIBERNATE_CMD) begin
                    pend <= PD_HIB;
                end
            end
        end else if (sn_shift) begin
            // data in is not looked at while serial bytes go out
            spi_so   <= tx_sh[7];
            so_drive <= 1'b1;
            tx_cnt   <= tx_cnt + 3'h1;
            if (sn_next) begin
                tx_sh    <= sn_byte(sn_value, byte_idx);
                byte_idx <= byte_idx + 3'h1;
            end else begin
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
        end
    end

    // power state: entry on chip select rise after a complete sleep opcode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pw  <= PW_ACTIVE;
            tmr <= '0;
        end else begin
            unique case (pw)
                PW_ACTIVE: begin
                    tmr <= '0;
                    if (cs_rise && pend == PD_DEEP) begin
                        pw <= PW_DS_ENTER;
                    end else if (cs_rise && pend == PD_HIB) begin
                        pw <= PW_HIB_ENTER;
                    end
                end
                PW_DS_ENTER: begin
                    tmr <= tmr_inc;
                    if (tmr_inc == DS_ENTRY_CYC) begin
                        pw  <= PW_DS;
                        tmr <= '0;
                    end
                end
                PW_DS: begin
                    // only chip select width counts; clock and data are don't care
                    tmr <= cs_low ? tmr_inc : '0;
                    if (cs_low && tmr_inc == DS_WAKE_CYC) begin
                        pw  <= PW_DS_EXIT;
                        tmr <= '0;
                    end
                end
                PW_DS_EXIT: begin
                    tmr <= tmr_inc;
                    if (tmr_inc == DS_EXIT_CYC) begin
                        pw <= PW_ACTIVE;
                    end
                end
                PW_HIB_ENTER: begin
                    tmr <= tmr_inc;
                    if (tmr_inc == HIB_ENTRY_CYC) begin
                        pw  <= PW_HIB;
                        tmr <= '0;
                    end
                end
                PW_HIB: begin
                    tmr <= '0;
                    if (cs_fall) begin
                        pw <= PW_HIB_EXIT;
                    end
                end
                PW_HIB_EXIT: begin
                    // the waking frame never reaches the decoder and is lost
                    tmr <= tmr_inc;
                    if (tmr_inc == HIB_EXIT_CYC) begin
                        pw <= PW_ACTIVE;
                    end
                end
                default: begin
                    pw  <= PW_ACTIVE;
                    tmr <= '0;
                end
            endcase
        end
    end

    assign spi_so_oe_n   = !(so_drive && active);
    assign pw_deep_sleep = (pw == PW_DS_ENTER) || (pw == PW_DS);
    assign pw_hibernate  = (pw == PW_HIB_ENTER) || (pw == PW_HIB);
    assign pw_waking     = (pw == PW_DS_EXIT) || (pw == PW_HIB_EXIT);

    // cycles spent in the hibernate exit interval; too long for a delay range
    logic [TMR_W-1:0] hib_wait;

    always_ff @(posedge clk) begin
        if (sys_rst || pw != PW_HIB_EXIT) begin
            hib_wait <= '0;
        end else begin
            hib_wait <= hib_wait + TMR_ONE;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_ds_entering;
        pw == PW_DS_ENTER [*8];
    endsequence

    sequence s_hib_woken;
        pw == PW_HIB ##1 pw == PW_HIB_EXIT;
    endsequence

    property p_so_off_rise;
        cs_rise |=> spi_so_oe_n;
    endproperty
    a_so_off_rise: assert property (p_so_off_rise) else $error("so driven after cs rise");

    property p_ds_quiet;
        (pw == PW_DS || pw == PW_DS_EXIT) |-> spi_so_oe_n && xf == XF_IGNORE;
    endproperty
    a_ds_quiet: assert property (p_ds_quiet) else $error("so active in deep sleep");

    property p_hib_quiet;
        (pw == PW_HIB || pw == PW_HIB_EXIT) |-> spi_so_oe_n && xf == XF_IGNORE;
    endproperty
    a_hib_quiet: assert property (p_hib_quiet) else $error("so active in hibernate");

    property p_ds_entry;
        active && cs_rise && pend == PD_DEEP |=> s_ds_entering ##[100:130] pw == PW_DS;
    endproperty
    a_ds_entry: assert property (p_ds_entry) else $error("deep sleep entry timing");

    property p_hib_entry;
        active && cs_rise && pend == PD_HIB |=> pw == PW_HIB_ENTER ##[30:45] pw == PW_HIB;
    endproperty
    a_hib_entry: assert property (p_hib_entry) else $error("hibernate entry timing");

    property p_hib_wake;
        pw == PW_HIB_EXIT |-> hib_wait < HIB_EXIT_CYC;
    endproperty
    a_hib_wake: assert property (p_hib_wake) else $error("hibernate exit too slow");

    property p_hib_mute;
        s_hib_woken |-> pw_waking && spi_so_oe_n;
    endproperty
    a_hib_mute: assert property (p_hib_mute) else $error("so on at hibernate wake");

    property p_hib_stay;
        pw == PW_HIB_EXIT && hib_wait < HIB_EXIT_CYC - TMR_ONE |=> pw == PW_HIB_EXIT;
    endproperty
    a_hib_stay: assert property (p_hib_stay) else $error("hibernate wake cut short");

    property p_ds_wake;
        pw == PW_DS && cs_low && tmr_inc == DS_WAKE_CYC |=> pw == PW_DS_EXIT
            ##[390:401] pw == PW_ACTIVE;
    endproperty
    a_ds_wake: assert property (p_ds_wake) else $error("deep sleep exit timing");

    property p_ds_hold;
        pw == PW_DS && !(cs_low && tmr_inc == DS_WAKE_CYC) |=> pw == PW_DS;
    endproperty
    a_ds_hold: assert property (p_ds_hold) else $error("deep sleep left early");

    property p_sn_first;
        sn_start |=> xf == XF_SERIAL && tx_sh == sn_value[7:0] && byte_idx == 3'h1;
    endproperty
    a_sn_first: assert property (p_sn_first) else $error("first serial byte wrong");

    property p_sn_wrap;
        sn_next && !cs_rise |=> tx_sh == sn_byte(sn_value, $past(byte_idx));
    endproperty
    a_sn_wrap: assert property (p_sn_wrap) else $error("serial byte order wrong");

    property p_sn_msb;
        sn_shift && !cs_rise |=> spi_so == $past(tx_sh[7]) && !spi_so_oe_n;
    endproperty
    a_sn_msb: assert property (p_sn_msb) else $error("serial bit order wrong");

    property p_oe_only_serial;
        !spi_so_oe_n |-> xf == XF_SERIAL;
    endproperty
    a_oe_only_serial: assert property (p_oe_only_serial) else $error("so driven outside read");

endmodule : snpm_core

// File: include/snpm_pkg.sv
package snpm_pkg;

    // link pins carried through the synchroniser: chip select, clock, data in
    localparam int          PIN_W        = 3;
    localparam int          PIN_CS       = 0;
    localparam int          PIN_SCK      = 1;
    localparam int          PIN_SI       = 2;

    localparam logic [7:0]  READ_SERIAL_CMD = 8'hC3;
    localparam logic [7:0]  DEEP_SLEEP_CMD  = 8'hBA;
    localparam logic [7:0]  HIBERNATE_CMD   = 8'hB9;

    localparam int          SN_BYTES     = 8;
    localparam int          SN_W         = 64;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    localparam logic [2:0]  SN_FIRST     = 3'h0;

    // array geometry: 32K rows of 64 bits, byte address splits row / byte-in-row
    localparam int          ADDR_W       = 18;
    localparam int          ROW_W        = 15;
    localparam int          ROW_LSB      = 3;

    // timing, figures in ns (plain defaults, no part value implied)
    localparam int          CLK_NS                      = 32'h0000_0019; // 25
    localparam int          DEEP_SLEEP_ENTRY_DELAY_NS   = 32'h0000_0BB8; // 3000
    localparam int          DEEP_SLEEP_WAKE_PULSE_NS    = 32'h0000_01C2; // 450
    localparam int          DEEP_SLEEP_EXIT_DELAY_NS    = 32'h0000_2710; // 10000
    localparam int          HIBERNATE_ENTRY_DELAY_NS    = 32'h0000_03E8; // 1000
    localparam int          HIBERNATE_EXIT_DELAY_NS     = 32'h0001_86A0; // 100000

    localparam int          TMR_W        = 12;
    // least times round up, longest times round down
    localparam logic [11:0] DS_ENTRY_CYC =
        12'((DEEP_SLEEP_ENTRY_DELAY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] DS_WAKE_CYC  =
        12'((DEEP_SLEEP_WAKE_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] DS_EXIT_CYC  = 12'(DEEP_SLEEP_EXIT_DELAY_NS / CLK_NS);
    localparam logic [11:0] HIB_ENTRY_CYC =
        12'((HIBERNATE_ENTRY_DELAY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] HIB_EXIT_CYC = 12'(HIBERNATE_EXIT_DELAY_NS / CLK_NS);
    localparam logic [11:0] TMR_ONE      = 12'h001;

    typedef enum logic [2:0] {
        PW_ACTIVE, PW_DS_ENTER, PW_DS, PW_DS_EXIT, PW_HIB_ENTER, PW_HIB, PW_HIB_EXIT
    } snpm_pw_e;

    typedef enum logic [1:0] {
        XF_IGNORE, XF_OPCODE, XF_SERIAL
    } snpm_xf_e;

    typedef enum logic [1:0] {
        PD_NONE, PD_DEEP, PD_HIB
    } snpm_pend_e;

endpackage : snpm_pkg

// File: hw/snpm_sync.sv
`timescale 1ns/1ps
module snpm_sync (
    input  wire logic                        clk,      // system clock
    input  wire logic                        sys_rst,  // sync reset, high
    input  wire logic [snpm_pkg::PIN_W-1:0]  pin_in,   // raw link pins
    output logic      [snpm_pkg::PIN_W-1:0]  pin_lvl,  // synchronised levels
    output logic      [snpm_pkg::PIN_W-1:0]  pin_rise, // rising edge pulse
    output logic      [snpm_pkg::PIN_W-1:0]  pin_fall  // falling edge pulse
);
    import snpm_pkg::*;

    logic [PIN_W-1:0] meta;
    logic [PIN_W-1:0] lvl;
    logic [PIN_W-1:0] prev;

    // chip select idles high, clock and data low
    localparam logic [PIN_W-1:0] PIN_IDLE = 3'h1;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta <= PIN_IDLE;
            lvl  <= PIN_IDLE;
            prev <= PIN_IDLE;
        end else begin
            meta <= pin_in;
            lvl  <= meta;
            prev <= lvl;
        end
    end

    assign pin_lvl  = lvl;
    assign pin_rise = lvl & ~prev;
    assign pin_fall = ~lvl & prev;

endmodule : snpm_sync

// File: hw/snpm_row_track.sv
`timescale 1ns/1ps
module snpm_row_track (
    input  wire logic                         clk,       // system clock
    input  wire logic                         sys_rst,   // sync reset, high
    input  wire logic                         acc_valid, // one byte accessed
    input  wire logic                         acc_first, // first byte of a burst
    input  wire logic [snpm_pkg::ADDR_W-1:0]  acc_addr,  // byte address
    output logic                              row_act,   // row access pulse
    output logic      [snpm_pkg::ROW_W-1:0]   row_idx    // row being accessed
);
    import snpm_pkg::*;

    logic [ROW_W-1:0] last_row;
    logic             have_row;
    wire  [ROW_W-1:0] acc_row  = acc_addr[ADDR_W-1:ROW_LSB];
    // a row is opened at each burst start and at each change of row, however many of its bytes are touched
    wire              new_row  = acc_valid && (acc_first || !have_row || acc_row != last_row);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            last_row <= '0;
            have_row <= 1'b0;
            row_act  <= 1'b0;
            row_idx  <= '0;
        end else begin
            row_act <= new_row;
            if (new_row) begin
                last_row <= acc_row;
                row_idx  <= acc_row;
                have_row <= 1'b1;
            end
        end
    end

endmodule : snpm_row_track

// File: bench/snpm_host.sv
`timescale 1ns/1ps
module snpm_host (
    input  wire logic clk,     // bench clock, 40 MHz
    output logic      cs_n,    // chip select, low active
    output logic      sck,     // serial clock, 200 ns inside frames
    output logic      si,      // data to device
    input  wire logic so,      // data from device
    input  wire logic so_oe_n  // device drives so when low
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end

    // outside a frame the data line toggles so a stale level never looks valid
    always @(posedge clk) if (cs_n) si <= ~si;

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk

    task automatic select(input logic lvl);
        @(posedge clk) cs_n <= lvl;
        wait_clk(4);
    endtask : select

    // chip select alone, clock and data left idle
    task automatic cs_pulse(input int n);
        @(posedge clk) cs_n <= 1'b0;
        wait_clk(n);
        cs_n <= 1'b1;
    endtask : cs_pulse

    // one byte, mode 0: data set with sck low, so sampled just before each fall
    task automatic xfer(input logic [7:0] tx, output logic [7:0] got, output logic [7:0] oe);
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            wait_clk(4);
            sck <= 1'b1;
            wait_clk(4);
            got[i] = so;
            oe[i]  = so_oe_n;
            sck <= 1'b0;
        end
    endtask : xfer
endmodule : snpm_host

// File: bench/serial_number_read_power_modes_tb.sv
`timescale 1ns/1ps
module serial_number_read_power_modes_tb;
    import snpm_pkg::*;
    logic                clk = 1'b0;
    logic                sys_rst;
    logic                spi_cs_n, spi_sck, spi_si, spi_so, spi_so_oe_n;
    logic [SN_W-1:0]     sn_value;
    logic [SN_W-1:0]     sn_init;
    logic                acc_valid;
    logic                acc_first;
    logic [ADDR_W-1:0]   acc_addr;
    logic                row_act, pw_deep_sleep, pw_hibernate, pw_waking;
    logic [ROW_W-1:0]    row_idx;
    wire  [2:0]          pw_vec = {pw_waking, pw_hibernate, pw_deep_sleep};
    int                  failures = 0;
    int                  checks_done = 0;
    int                  last_row;
    logic [31:0]         seed = 32'h4da3_89f6;
    logic [7:0]          got, oe;
    logic [7:0]          exp_q[$];
    logic [ADDR_W-1:0]   addr, base;
    logic                seen, exp_act;

    always #12.5 clk = ~clk;

    snpm_core DUT (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .spi_cs_n      (spi_cs_n),
        .spi_sck       (spi_sck),
        .spi_si        (spi_si),
        .spi_so        (spi_so),
        .spi_so_oe_n   (spi_so_oe_n),
        .sn_value      (sn_value),
        .acc_valid     (acc_valid),
        .acc_first     (acc_first),
        .acc_addr      (acc_addr),
        .row_act       (row_act),
        .row_idx       (row_idx),
        .pw_deep_sleep (pw_deep_sleep),
        .pw_hibernate  (pw_hibernate),
        .pw_waking     (pw_waking)
    );

    snpm_host host (
        .clk     (clk),
        .cs_n    (spi_cs_n),
        .sck     (spi_sck),
        .si      (spi_si),
        .so      (spi_so),
        .so_oe_n (spi_so_oe_n)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [63:0] obs, input logic [63:0] exp, input string what);
        checks_done++;
        if (obs !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, obs, exp);
        end
    endtask : check

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic wait_pw(input int which, input logic lvl, input int lim);
        int n;
        n = 0;
        while (pw_vec[which] !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            failures++;
            $display("MISMATCH t=%0t power state %0d never reached %b", $time, which, lvl);
            conclude();
        end
    endtask : wait_pw

    task automatic read_sn(input int nbytes);
        host.select(1'b0);
        host.xfer(READ_SERIAL_CMD, got, oe);
        for (int k = 0; k < nbytes; k++) begin
            seed = lfsr(seed);
            host.xfer(seed[7:0], got, oe);
            check(got, exp_q[k % exp_q.size()], "serial byte");
            check(oe, 8'h00, "so enable during read");
        end
        host.select(1'b1);
        host.wait_clk(2);
        check(spi_so_oe_n, 1'b1, "so off after cs rise");
    endtask : read_sn

    // dummy frame while asleep or waking: no byte may be driven
    task automatic silent_frame;
        host.select(1'b0);
        host.xfer(READ_SERIAL_CMD, got, oe);
        check(oe, 8'hff, "so driven while asleep");
        host.xfer(8'h00, got, oe);
        check(oe, 8'hff, "so driven while waking");
        host.select(1'b1);
    endtask : silent_frame

    initial begin
        sys_rst   <= 1'b1;
        acc_valid <= 1'b0;
        acc_first <= 1'b0;
        acc_addr  <= '0;
        seed = lfsr(seed);
        sn_init[31:0] = seed;
        seed = lfsr(seed);
        sn_init[63:32] = seed;
        sn_value <= sn_init;
        for (int k = 0; k < SN_BYTES; k++) exp_q.push_back(sn_init[8*k +: 8]);
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        host.wait_clk(4);

        read_sn(SN_BYTES + 3);
        host.select(1'b0);
        host.xfer(8'h3c, got, oe);
        host.xfer(8'h00, got, oe);
        check(oe, 8'hff, "unknown opcode answered");
        host.select(1'b1);
        $display("test serial read done");

        host.select(1'b0);
        host.xfer(DEEP_SLEEP_CMD, got, oe);
        host.select(1'b1);
        wait_pw(0, 1'b1, 10);
        host.wait_clk(150);
        host.cs_pulse(10);
        host.wait_clk(30);
        check(pw_vec, 3'b001, "short pulse woke deep sleep");
        silent_frame();
        check(pw_waking, 1'b1, "deep sleep exit ended early");
        wait_pw(2, 1'b0, 420);
        read_sn(2);
        $display("test deep sleep done");

        host.select(1'b0);
        host.xfer(HIBERNATE_CMD, got, oe);
        host.select(1'b1);
        wait_pw(1, 1'b1, 10);
        host.wait_clk(60);
        silent_frame();
        check(pw_waking, 1'b1, "hibernate exit ended early");
        wait_pw(2, 1'b0, 4000);
        read_sn(2);
        $display("test hibernate done");

        last_row = -1;
        seed = lfsr(seed);
        base = {seed[17:3], 3'h5};
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            addr = (i < 4) ? ADDR_W'(base + ADDR_W'(i)) : seed[17:0];
            @(posedge clk);
            acc_valid <= 1'b1;
            acc_first <= (i == 0 || i == 6);
            acc_addr  <= addr;
            @(posedge clk);
            acc_valid <= 1'b0;
            @(negedge clk) seen = row_act;
            @(negedge clk) seen = seen | row_act;
            exp_act = (i == 0 || i == 6 || int'(addr[17:3]) != last_row);
            check(seen, exp_act, "row open pulse");
            if (exp_act) last_row = int'(addr[17:3]);
            check(row_idx, last_row[14:0], "row index");
        end
        $display("test row tracking done");
        conclude();
    end
endmodule : serial_number_read_power_modes_tb
